// File: eru_div.sv
`timescale 1ns/1ps
// ****************************************************************
// restoring divider, one quotient bit per clock
// ****************************************************************
module eru_div
	import eru_pkg::*;
#(
	parameter int W = 24
) (
	input  wire logic sys_clk,  // system clock
	input  wire logic rstn,     // async reset, active low
	eru_div_if.srv    d         // request/answer bundle
);

	logic [W-1:0] rem_r, rem_nxt;
	logic [W-1:0] quo_r, quo_nxt;
	logic [7:0]   cnt_r, cnt_nxt;
	logic         done_r, done_nxt;
	logic [W:0]   trial;

	// next remainder, quotient and step count
	always_comb
	begin
		rem_nxt  = rem_r;
		quo_nxt  = quo_r;
		cnt_nxt  = cnt_r;
		done_nxt = 1'b0;
		trial    = {rem_r, quo_r[W-1]};
		if (d.start)
		begin
			rem_nxt = '0;
			quo_nxt = d.num;
			cnt_nxt = 8'(W);
		end
		else if (cnt_r != 8'h00)
		begin
			if (trial >= {1'b0, d.den})
			begin
				rem_nxt = W'(trial - {1'b0, d.den});
				quo_nxt = {quo_r[W-2:0], 1'b1};
			end
			else
			begin
				rem_nxt = trial[W-1:0];
				quo_nxt = {quo_r[W-2:0], 1'b0};
			end
			cnt_nxt  = cnt_r - 8'h01;
			done_nxt = (cnt_r == 8'h01);
		end
	end

	// register stage
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rem_r  <= '0;
			quo_r  <= '0;
			cnt_r  <= 8'h00;
			done_r <= 1'b0;
		end
		else
		begin
			rem_r  <= rem_nxt;
			quo_r  <= quo_nxt;
			cnt_r  <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign d.done = done_r;
	assign d.quo  = quo_r;

	if (W < 2 || W > 255)
		$error("eru_div: width out of range");
endmodule

// File: eru_div_if.sv
`timescale 1ns/1ps
// ****************************************************************
// request/answer bundle of the sequential divider
// ****************************************************************
interface eru_div_if #(parameter int W = 24) ();
	logic         start;  // one-cycle request
	logic [W-1:0] num;    // dividend, held while busy
	logic [W-1:0] den;    // divisor, held while busy
	logic         done;   // one-cycle completion
	logic [W-1:0] quo;    // quotient, held until next start

	modport req (output start, output num, output den,
		input done, input quo);
	modport srv (input start, input num, input den,
		output done, output quo);
endinterface

// File: eru_fifo.sv
`timescale 1ns/1ps
// ****************************************************************
// output fifo with valid/ready on both sides
// ****************************************************************
module eru_fifo
	import eru_pkg::*;
#(
	parameter int W     = 28,
	parameter int DEPTH = 8
) (
	input  wire logic         sys_clk,    // system clock
	input  wire logic         rstn,       // async reset, active low
	input  wire logic         in_valid,   // write request
	output logic              in_ready,   // not full
	input  wire logic [W-1:0] in_data,    // write word
	output logic              out_valid,  // not empty
	input  wire logic         out_ready,  // drain accepts
	output logic [W-1:0]      out_data    // head word
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_r [0:DEPTH-1];
	logic [AW:0]  wr_r, wr_nxt;
	logic [AW:0]  rd_r, rd_nxt;
	logic         push;
	logic         pop;

	// full/empty from pointers with a wrap bit
	assign in_ready  = !((wr_r[AW] != rd_r[AW]) &&
		(wr_r[AW-1:0] == rd_r[AW-1:0]));
	assign out_valid = (wr_r != rd_r);
	assign out_data  = mem_r[rd_r[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer advance
	always_comb
	begin
		wr_nxt = push ? wr_r + 1'b1 : wr_r;
		rd_nxt = pop ? rd_r + 1'b1 : rd_r;
	end

	// pointer registers
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_r <= '0;
			rd_r <= '0;
		end
		else
		begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
		end
	end

	// storage, no reset needed
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem_r[wr_r[AW-1:0]] <= in_data;
	end

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		$error("eru_fifo: depth must be a power of two, at least 2");
endmodule

// File: eru_mem_model.sv
`timescale 1ns/1ps
// ****************************************************************
// acquisition memory model, one cycle read latency
// ****************************************************************
module eru_mem_model
	import eru_pkg::*;
(
	input  wire logic        sys_clk,   // system clock
	input  wire logic        rstn,      // async reset, active low
	input  wire logic        src_rd,    // read strobe
	input  wire logic [15:0] src_addr,  // read address
	output logic [IN_W-1:0]  src_data,  // sample
	output logic             src_ovf    // overflow flag
);
	logic [IN_W-1:0] mem [0:255];  // loaded by the bench
	logic            ovm [0:255];  // overflow marks

	// answer after the strobe, scramble the lines otherwise
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			src_data <= 8'h00;
			src_ovf  <= 1'b0;
		end
		else if (src_rd)
		begin
			src_data <= mem[src_addr[7:0]];
			src_ovf  <= ovm[src_addr[7:0]];
		end
		else
		begin
			src_data <= ~src_data;
			src_ovf  <= ~src_ovf;
		end
	end
endmodule

// File: eru_pkg.sv
// ****************************************************************
// shared constants and helpers for the resolution filter
// ****************************************************************
package eru_pkg;

	// sample and result widths
	localparam int IN_W   = 8;                  // raw quantized sample
	localparam int FRAC_W = 3;                  // up to three extra bits
	localparam int OUT_W  = IN_W + FRAC_W;      // filtered word
	localparam int LEN_W  = 7;                  // filter length field
	localparam int SEL_W  = 3;                  // filter selector
	localparam int ACC_W  = 20;                 // sample x tap sum
	localparam int NRM_W  = 24;                 // normalising divider
	localparam int BW_W   = 40;                 // bandwidth divider
	localparam int PCT_W  = 10;                 // bandwidth, 0.1 % units
	localparam int NUM_FILT = 6;

	// impulse lengths per selector, samples
	localparam logic [LEN_W-1:0] FLT_LEN [0:NUM_FILT-1] = '{
		7'h02, 7'h05, 7'h0a, 7'h18, 7'h33, 7'h75};

	// -3 dB bandwidth in 0.1 % of nyquist (also thousandths of it)
	localparam logic [PCT_W-1:0] FLT_BW [0:NUM_FILT-1] = '{
		10'h1f4, 10'h0f1, 10'h079, 10'h03a, 10'h01d, 10'h010};

	// hz = code * 5e8 / interval_ps  (code in thousandths of nyquist)
	localparam logic [BW_W-1:0] BW_SCALE = 40'h001dcd6500;

	// control states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_MAC,
		ST_DRAIN,
		ST_DIV,
		ST_PUSH
	} eru_state_t;

	// symmetric triangular tap: min(k+1, len-k), all positive
	function automatic logic [LEN_W-1:0] eru_coef(
		input logic [LEN_W-1:0] len,
		input logic [LEN_W-1:0] k);
		logic [LEN_W-1:0] up;
		logic [LEN_W-1:0] dn;
		up = k + 7'h01;
		dn = len - k;
		eru_coef = (up < dn) ? up : dn;
	endfunction

	// exact sum of the taps of a given length
	function automatic logic [12:0] eru_norm(input logic [LEN_W-1:0] len);
		logic [12:0] m;
		m = {7'h00, len[6:1]};
		if (len[0])
			eru_norm = (m + 13'h0001) * (m + 13'h0001);
		else
			eru_norm = m * (m + 13'h0001);
	endfunction

endpackage

// File: eru_top.sv
// Function
// - six filters, lengths 2 to 117
// - every filter is low-pass
// - symmetric taps give exact linear phase
// - output aligned to source, delay removed
// - taps normalised to exact unity DC gain
// - clean input never yields overflowed output
// - overflowed input filtered anyway, flagged
// - report bandwidth as percent and hertz
// - output shorter by exactly filter length
// - refuse record too short for output
// - 8-bit input, resolution not accuracy
`timescale 1ns/1ps
// ****************************************************************
// resolution-enhancement fir over a stored record
// ****************************************************************
module eru_top
	import eru_pkg::*;
#(
	parameter int ADDR_W     = 16,
	parameter int DT_W       = 32,
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic              sys_clk,     // 40 MHz system clock
	input  wire logic              rstn,        // async reset, active low
	input  wire logic              start,       // begin a record
	input  wire logic [SEL_W-1:0]  filt_sel,    // filter 0..5
	input  wire logic [ADDR_W-1:0] rec_len,     // source samples
	input  wire logic [DT_W-1:0]   sample_ps,   // sample interval, ps
	output logic                   src_rd,      // source read strobe
	output logic [ADDR_W-1:0]      src_addr,    // source address
	input  wire logic [IN_W-1:0]   src_data,    // sample, next cycle
	input  wire logic              src_ovf,     // sample overflowed
	output logic                   out_valid,   // result available
	input  wire logic              out_ready,   // trace buffer takes
	output logic [ADDR_W-1:0]      out_addr,    // result position
	output logic [OUT_W-1:0]       out_data,    // filtered value
	output logic                   out_ovf,     // may be incorrect
	output logic                   busy,        // record in progress
	output logic                   done,        // record finished
	output logic                   refused,     // start rejected
	output logic [PCT_W-1:0]       bw_pct,      // bandwidth, 0.1 %
	output logic [BW_W-1:0]        bw_hz,       // bandwidth, hz
	output logic                   bw_valid     // bw_hz is current
);

	localparam int FW = ADDR_W + OUT_W + 1;

	// ************************************************************
	// state
	// ************************************************************
	eru_state_t          state_r, state_nxt;
	logic [ADDR_W-1:0]   j_r, j_nxt;         // output index
	logic [ADDR_W-1:0]   cnt_r, cnt_nxt;     // output count
	logic [LEN_W-1:0]    k_r, k_nxt;         // tap index
	logic [LEN_W-1:0]    len_r, len_nxt;
	logic [12:0]         nrm_r, nrm_nxt;
	logic [ACC_W-1:0]    acc_r, acc_nxt;
	logic                ovf_r, ovf_nxt;
	logic                rd_r, rd_nxt;
	logic [ADDR_W-1:0]   addr_r, addr_nxt;
	logic [LEN_W-1:0]    coef_a_r, coef_a_nxt;
	logic [LEN_W-1:0]    coef_d_r, coef_d_nxt;
	logic                vld_d_r, vld_d_nxt;
	logic                busy_r, busy_nxt;
	logic                done_r, done_nxt;
	logic                ref_r, ref_nxt;
	logic [PCT_W-1:0]    pct_r, pct_nxt;
	logic [DT_W-1:0]     dt_r, dt_nxt;
	logic                bwv_r, bwv_nxt;
	logic [BW_W-1:0]     hz_r, hz_nxt;
	logic                nst_r, nst_nxt;
	logic                bst_r, bst_nxt;

	logic                push;
	logic                fifo_rdy;
	logic [FW-1:0]       push_word;
	logic [FW-1:0]       pop_word;
	logic [LEN_W-1:0]    sel_len;
	logic [ADDR_W-1:0]   center;

	eru_div_if #(.W(NRM_W)) nrm_if ();
	eru_div_if #(.W(BW_W))  bwd_if ();

	// ************************************************************
	// dividers: gain normalisation and bandwidth in hertz
	// ************************************************************
	eru_div #(.W(NRM_W)) u_nrm (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.d       (nrm_if.srv)
	);

	eru_div #(.W(BW_W)) u_bwd (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.d       (bwd_if.srv)
	);

	// (acc*8 + sum/2) / sum: exact unity gain, rounded, 3 frac bits
	assign nrm_if.start = nst_r;
	assign nrm_if.num   = {1'b0, acc_r, 3'h0} +
		{12'h000, nrm_r[12:1]};
	assign nrm_if.den   = {11'h000, nrm_r};

	// hz = code * 5e8 / interval_ps
	assign bwd_if.start = bst_r;
	assign bwd_if.num   = BW_W'(pct_r * BW_SCALE);
	assign bwd_if.den   = BW_W'(dt_r);

	// ************************************************************
	// output fifo towards the trace buffer
	// ************************************************************
	assign push      = (state_r == ST_PUSH);
	assign center    = j_r + {{(ADDR_W-6){1'b0}}, len_r[6:1]};
	assign push_word = {ovf_r, center, nrm_if.quo[OUT_W-1:0]};

	eru_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.in_valid  (push),
		.in_ready  (fifo_rdy),
		.in_data   (push_word),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (pop_word)
	);

	assign out_ovf  = pop_word[FW-1];
	assign out_addr = pop_word[FW-2:OUT_W];
	assign out_data = pop_word[OUT_W-1:0];

	// length of the requested filter, zero if none
	assign sel_len = (filt_sel < SEL_W'(NUM_FILT)) ?
		FLT_LEN[filt_sel] : 7'h00;

	// ************************************************************
	// control: fetch window, accumulate, normalise, emit
	// ************************************************************
	always_comb
	begin
		state_nxt  = state_r;
		j_nxt      = j_r;
		cnt_nxt    = cnt_r;
		k_nxt      = k_r;
		len_nxt    = len_r;
		nrm_nxt    = nrm_r;
		acc_nxt    = acc_r;
		ovf_nxt    = ovf_r;
		addr_nxt   = addr_r;
		busy_nxt   = busy_r;
		pct_nxt    = pct_r;
		dt_nxt     = dt_r;
		bwv_nxt    = bwv_r;
		hz_nxt     = hz_r;
		rd_nxt     = 1'b0;
		coef_a_nxt = coef_a_r;
		coef_d_nxt = coef_a_r;
		vld_d_nxt  = rd_r;
		done_nxt   = 1'b0;
		ref_nxt    = 1'b0;
		nst_nxt    = 1'b0;
		bst_nxt    = 1'b0;

		// sample returned one cycle after its read strobe
		if (vld_d_r)
		begin
			acc_nxt = acc_r + ACC_W'(src_data * coef_d_r);
			ovf_nxt = ovf_r | src_ovf;
		end

		// bandwidth result
		if (bwd_if.done)
		begin
			hz_nxt  = bwd_if.quo;
			bwv_nxt = 1'b1;
		end

		unique case (state_r)
			ST_IDLE:
			begin
				if (start)
				begin
					// need at least one output beyond the loss
					if (sel_len == 7'h00 ||
						rec_len <= {{(ADDR_W-LEN_W){1'b0}}, sel_len})
						ref_nxt = 1'b1;
					else
					begin
						len_nxt   = sel_len;
						nrm_nxt   = eru_norm(sel_len);
						cnt_nxt   = rec_len -
							{{(ADDR_W-LEN_W){1'b0}}, sel_len};
						j_nxt     = '0;
						k_nxt     = 7'h00;
						acc_nxt   = '0;
						ovf_nxt   = 1'b0;
						busy_nxt  = 1'b1;
						pct_nxt   = FLT_BW[filt_sel];
						dt_nxt    = sample_ps;
						bwv_nxt   = 1'b0;
						bst_nxt   = 1'b1;
						state_nxt = ST_MAC;
					end
				end
			end
			ST_MAC:
			begin
				// one sequential read per tap
				rd_nxt     = 1'b1;
				addr_nxt   = j_r + {{(ADDR_W-LEN_W){1'b0}}, k_r};
				coef_a_nxt = eru_coef(len_r, k_r);
				k_nxt      = k_r + 7'h01;
				if (k_r == len_r - 7'h01)
					state_nxt = ST_DRAIN;
			end
			ST_DRAIN:
			begin
				if (!rd_r && !vld_d_r)
				begin
					nst_nxt   = 1'b1;
					state_nxt = ST_DIV;
				end
			end
			ST_DIV:
			begin
				if (nrm_if.done)
					state_nxt = ST_PUSH;
			end
			ST_PUSH:
			begin
				// stall here while the trace buffer lags
				if (fifo_rdy)
				begin
					j_nxt   = j_r + 1'b1;
					k_nxt   = 7'h00;
					acc_nxt = '0;
					ovf_nxt = 1'b0;
					if (j_r == cnt_r - 1'b1)
					begin
						busy_nxt  = 1'b0;
						done_nxt  = 1'b1;
						state_nxt = ST_IDLE;
					end
					else
						state_nxt = ST_MAC;
				end
			end
		endcase
	end

	// control registers
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r  <= ST_IDLE;
			j_r      <= '0;
			cnt_r    <= '0;
			k_r      <= 7'h00;
			len_r    <= 7'h00;
			nrm_r    <= 13'h0000;
			acc_r    <= '0;
			ovf_r    <= 1'b0;
			rd_r     <= 1'b0;
			addr_r   <= '0;
			coef_a_r <= 7'h00;
			coef_d_r <= 7'h00;
			vld_d_r  <= 1'b0;
			busy_r   <= 1'b0;
			done_r   <= 1'b0;
			ref_r    <= 1'b0;
			pct_r    <= 10'h000;
			dt_r     <= '0;
			bwv_r    <= 1'b0;
			hz_r     <= '0;
			nst_r    <= 1'b0;
			bst_r    <= 1'b0;
		end
		else
		begin
			state_r  <= state_nxt;
			j_r      <= j_nxt;
			cnt_r    <= cnt_nxt;
			k_r      <= k_nxt;
			len_r    <= len_nxt;
			nrm_r    <= nrm_nxt;
			acc_r    <= acc_nxt;
			ovf_r    <= ovf_nxt;
			rd_r     <= rd_nxt;
			addr_r   <= addr_nxt;
			coef_a_r <= coef_a_nxt;
			coef_d_r <= coef_d_nxt;
			vld_d_r  <= vld_d_nxt;
			busy_r   <= busy_nxt;
			done_r   <= done_nxt;
			ref_r    <= ref_nxt;
			pct_r    <= pct_nxt;
			dt_r     <= dt_nxt;
			bwv_r    <= bwv_nxt;
			hz_r     <= hz_nxt;
			nst_r    <= nst_nxt;
			bst_r    <= bst_nxt;
		end
	end

	// status outputs
	assign src_rd   = rd_r;
	assign src_addr = addr_r;
	assign busy     = busy_r;
	assign done     = done_r;
	assign refused  = ref_r;
	assign bw_pct   = pct_r;
	assign bw_hz    = hz_r;
	assign bw_valid = bwv_r;

	if (ADDR_W < 8 || ADDR_W > 24 || DT_W < 1 || DT_W > BW_W)
		$error("eru_top: unsupported address or interval width");
endmodule

// File: eru_top_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// port checker of the resolution filter
// ****************************************************************
module eru_top_sva
	import eru_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input wire logic              sys_clk,    // system clock
	input wire logic              rstn,       // async reset, active low
	input wire logic              start,      // begin a record
	input wire logic [SEL_W-1:0]  filt_sel,   // filter selector
	input wire logic              src_rd,     // source read strobe
	input wire logic [ADDR_W-1:0] src_addr,   // source address
	input wire logic              out_valid,  // result available
	input wire logic              out_ready,  // trace buffer takes
	input wire logic [ADDR_W-1:0] out_addr,   // result position
	input wire logic [OUT_W-1:0]  out_data,   // filtered value
	input wire logic              busy,       // record in progress
	input wire logic              done,       // record finished
	input wire logic              refused,    // start rejected
	input wire logic [PCT_W-1:0]  bw_pct,     // bandwidth, 0.1 %
	input wire logic              bw_valid    // bw_hz is current
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	// accepted start, answered by busy next cycle
	sequence s_acc;
		start && !busy ##1 busy;
	endsequence

	a_bw_pct_set: assert property (s_acc
		|-> bw_pct == FLT_BW[$past(filt_sel)])
		else $error("bandwidth percent wrong at start");
	a_bw_hz_wait: assert property (s_acc
		|-> !bw_valid ##[1:80] bw_valid)
		else $error("bandwidth in hertz late or stale");
	a_rd_ascend: assert property (src_rd && $past(src_rd)
		|-> src_addr == $past(src_addr) + 1'b1)
		else $error("source reads not sequential");
	a_rd_in_busy: assert property (src_rd |-> busy)
		else $error("source read while idle");
	a_done_end: assert property (done |-> !busy && $past(busy))
		else $error("done without ending a record");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_refuse_why: assert property (refused
		|-> $past(start) && !$past(busy) && !busy)
		else $error("refusal without an idle start");
	a_busy_cause: assert property ($rose(busy) |-> $past(start))
		else $error("busy rose without start");
	a_out_hold: assert property (out_valid && !out_ready
		|=> out_valid && $stable(out_data) && $stable(out_addr))
		else $error("output word changed before taken");
endmodule

bind eru_top eru_top_sva #(.ADDR_W(ADDR_W)) u_sva (.sys_clk, .rstn, .start,
	.filt_sel, .src_rd, .src_addr, .out_valid, .out_ready, .out_addr,
	.out_data, .busy, .done, .refused, .bw_pct, .bw_valid);

// File: tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench of the resolution filter
// ****************************************************************
module tb_top
	import eru_pkg::*;
;
	typedef struct packed {
		logic [15:0]      a;
		logic [OUT_W-1:0] d;
		logic             o;
	} eru_exp_t;

	logic             sys_clk = 1'b0;  // 40 MHz
	logic             rstn = 1'b0;     // reset, active low
	logic             start = 1'b0;    // begin a record
	logic [2:0]       filt_sel = 3'h0; // filter selector
	logic [15:0]      rec_len = 16'h0000;  // source length
	logic [31:0]      sample_ps = 32'h0;   // sample interval
	logic             out_ready = 1'b0;    // trace buffer takes
	logic             stall = 1'b0;        // hold the far side
	logic             rdy;                 // ready chosen this cycle
	int               dones = 0;           // done pulses seen
	logic             src_rd;
	logic [15:0]      src_addr;
	logic [IN_W-1:0]  src_data;
	logic             src_ovf;
	logic             out_valid;
	logic [15:0]      out_addr;
	logic [OUT_W-1:0] out_data;
	logic             out_ovf;
	logic             busy;
	logic             done;
	logic             refused;
	logic [PCT_W-1:0] bw_pct;
	logic [BW_W-1:0]  bw_hz;
	logic             bw_valid;
	eru_exp_t         exq [$];     // expected words, oldest first
	eru_exp_t         e;           // word being compared
	int               miscompares = 0;
	int               cmp_count = 0;
	int               lens [6] = '{2, 5, 10, 24, 51, 117};
	int               bws [6] = '{500, 241, 121, 58, 29, 16};

	always #12.5 sys_clk = ~sys_clk;

	eru_top u_eru_top (.sys_clk, .rstn, .start, .filt_sel, .rec_len,
		.sample_ps, .src_rd, .src_addr, .src_data, .src_ovf, .out_valid,
		.out_ready, .out_addr, .out_data, .out_ovf, .busy, .done,
		.refused, .bw_pct, .bw_hz, .bw_valid);
	eru_mem_model u_mem (.sys_clk, .rstn, .src_rd, .src_addr, .src_data,
		.src_ovf);

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %0h expected %0h",
				$time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one bounded step of a wait
	task automatic tick(inout int t, input int lim);
		t++;
		if (t > lim)
		begin
			miscompares++;
			$display("wait ran out at %0t", $time);
			wrap_up();
		end
		else
			@(negedge sys_clk);
	endtask

	task automatic refuse(input int sel, input int len);
		start = 1'b1;
		filt_sel = 3'(sel);
		rec_len = 16'(len);
		@(negedge sys_clk);
		start = 1'b0;
		chk(refused, 1'b1);
		chk(busy, 1'b0);
		@(negedge sys_clk);
		$display("test refuse sel %0d len %0d over", sel, len);
	endtask

	// mode 0 random data, 1 level input, 2 far side stalls
	task automatic run(input int sel, input int n, input int ovp,
		input int mode, input int ps);
		int          L, m, s, acc, c, t, d0;
		logic        o;
		logic [63:0] hz;
		L = lens[sel];
		m = L / 2;
		s = (L % 2) ? (m + 1) * (m + 1) : m * (m + 1);
		for (int k = 0; k < L + n; k++)
		begin
			u_mem.mem[k] = (mode == 1) ? 8'hc5 : 8'($urandom);
			u_mem.ovm[k] = (k == ovp);
		end
		for (int j = 0; j < n; j++)
		begin
			acc = 0;
			o = 1'b0;
			for (int k = 0; k < L; k++)
			begin
				c = (k + 1 < L - k) ? k + 1 : L - k;
				acc += u_mem.mem[j + k] * c;
				o |= u_mem.ovm[j + k];
			end
			exq.push_back('{16'(j + m), 11'((acc * 8 + s / 2) / s), o});
		end
		stall = (mode == 2);
		d0 = dones;
		start = 1'b1;
		filt_sel = 3'(sel);
		rec_len = 16'(L + n);
		sample_ps = 32'(ps);
		@(negedge sys_clk);
		start = 1'b0;
		chk(busy, 1'b1);
		chk(bw_pct, bws[sel]);
		t = 0;
		while (bw_valid !== 1'b1)
			tick(t, 100);
		hz = ps ? 64'(bws[sel]) * 64'd500000000 / ps : {40{1'b1}};
		chk(bw_hz, hz);
		if (mode == 2)
			repeat (400) @(negedge sys_clk);
		stall = 1'b0;
		// short records may end before the bandwidth is ready
		t = 0;
		while (busy !== 1'b0)
			tick(t, 20000);
		@(negedge sys_clk);
		chk(dones, d0 + 1);
		t = 0;
		while (exq.size() != 0)
			tick(t, 500);
		repeat (4) @(negedge sys_clk);
		chk(out_valid, 1'b0);
		$display("test sel %0d mode %0d over", sel, mode);
	endtask

	// ****************************************************************
	// far side and result check
	// ****************************************************************
	// ready for the coming edge; a word valid now is taken there
	always @(negedge sys_clk)
	begin
		rdy = !stall && ($urandom % 4 != 0);
		out_ready <= rdy;
		if (rstn && out_valid === 1'b1 && rdy)
		begin
			e = (exq.size() != 0) ? exq.pop_front() : '1;
			chk(out_addr, e.a);
			chk(out_data, e.d);
			chk(out_ovf, e.o);
		end
	end

	// count done pulses between edges, where they are settled
	always @(negedge sys_clk)
		if (done === 1'b1)
			dones++;

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		void'($urandom(51841));
		repeat (5) @(negedge sys_clk);
		rstn = 1'b1;
		for (int i = 6; i < 8; i++)
			refuse(i, 200);
		for (int i = 0; i < 6; i++)
			refuse(i, lens[i]);
		for (int i = 0; i < 6; i++)
			run(i, 1 + $urandom % 4, -1, 0, $urandom_range(90000, 1000));
		run(3, 3, -1, 1, 800);
		run(2, 8, 5, 0, 0);
		run(0, 12, -1, 2, 4000);
		wrap_up();
	end
endmodule
